// ---- rtl/sfspi_pkg.sv ----
// Constants shared by the solenoid fault serial slave
package sfspi_pkg;
  // ==========================================================
  // Frame geometry
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NUM_CH = 5;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  // Least accepted pulse count, and the count that wraps back to it
  localparam logic [CNT_W-1:0] FRAME_MIN = 5'h10;
  localparam logic [CNT_W-1:0] FRAME_WRAP = 5'h17;
  localparam logic [3:0] TX_MSB = 4'hf;
  // ==========================================================
  // Status byte layout: channel index (0 = channel 1) per bit
  localparam int unsigned POS_CH4 = 3;
  localparam int unsigned POS_CH3 = 2;
  localparam int unsigned POS_CH2 = 1;
  localparam int unsigned POS_CH1 = 0;
  localparam int unsigned POS_CH5 = 4;
  localparam logic [2:0] STAT_PAD = 3'h0;
  // ==========================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [NUM_CH-1:0] FLAGS_RST = 5'h00;
  // Highest serial clock the far end may use
  localparam int unsigned SCLK_MAX_KHZ = 3200;
endpackage

// ---- rtl/sfspi_slave.sv ----
// Serial slave that reports latched solenoid faults and echoes a byte
// ==========================================================
// Notes on behaviour
// - Serial input captured on each rising serial clock edge while selected.
// - Serial output advances on each falling serial clock edge while selected.
// - Deselected: clock and input ignored, output not driven.
// - Select falling enables output and loads current status for shifting.
// - Select rising releases output and applies the received command word.
// - Accept 16 or 16 plus multiple of 8 pulses; discard others.
// - Words travel MSB first; shift path is first-in first-out.
// - Faulted channel reads one, healthy channel reads zero.
// - Status byte goes out first in a 16-bit frame.
// - Second byte returns the low byte received in the last accepted frame.
// - Command word takes received bits on select rising; needs 16 bits.
// - Active-high reset pin clears fault flags and registers.
// - Status bits 15..11 carry channels 4,3,2,1,5.
// - Three low bits of status byte are zero.
// - Accepted frame end clears latched fault flags.
// - Reset pin high clears registers and keeps output undriven.
`timescale 1ns/10ps
`default_nettype none
module sfspi_slave import sfspi_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk_link,
  input wire logic cs_n,
  input wire logic si,
  input wire logic reset_pin,
  input wire logic [NUM_CH-1:0] fault_set,
  output logic so,
  output logic so_oe,
  output logic [WORD_W-1:0] cmd_word,
  output logic [BYTE_W-1:0] echo_byte,
  output logic [NUM_CH-1:0] fault_flags,
  output logic frame_done,
  output logic frame_err
);

  function automatic logic [BYTE_W-1:0] status_of(
    input logic [NUM_CH-1:0] f
  );
    status_of = {f[POS_CH4], f[POS_CH3], f[POS_CH2], f[POS_CH1],
                 f[POS_CH5], STAT_PAD};
  endfunction

  // ==========================================================
  // System domain synchronisers and link clear
  logic cs_s1, cs_s2, cs_s3;
  logic rp_s1, rp_s2;
  logic tg_s1, tg_s2, tog_seen;
  logic link_clr;
  logic frame_tog;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      rp_s1 <= 1'b0;
      rp_s2 <= 1'b0;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      rp_s1 <= reset_pin;
      rp_s2 <= rp_s1;
      tg_s1 <= frame_tog;
      tg_s2 <= tg_s1;
    end
  end

  // Link flops clear from this flop, one edge after reset is seen
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link_clr <= 1'b1;
    end else begin
      link_clr <= 1'b0;
    end
  end

  // ==========================================================
  // Link domain: capture, pulse count, output shift
  logic [WORD_W-1:0] rx_shift;
  logic [CNT_W-1:0] cnt;
  logic started;
  logic fell;
  logic so_bit;
  logic [WORD_W-1:0] tx_word;

  // Frame start marker, cleared while deselected
  always_ff @(posedge sclk_link or posedge cs_n) begin
    if (cs_n) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  // Pulse count runs 1..23, then each further eight pulses land on 16
  always_ff @(posedge sclk_link or posedge link_clr) begin
    if (link_clr) begin
      rx_shift <= WORD_RST;
      cnt <= CNT_ZERO;
      frame_tog <= 1'b0;
    end else if (!cs_n) begin
      rx_shift <= {rx_shift[WORD_W-2:0], si};
      if (!started) begin
        cnt <= CNT_ONE;
        frame_tog <= ~frame_tog;
      end else if (cnt == FRAME_WRAP) begin
        cnt <= FRAME_MIN;
      end else begin
        cnt <= cnt + CNT_ONE;
      end
    end
  end

  always_ff @(negedge sclk_link or posedge cs_n) begin
    if (cs_n) begin
      fell <= 1'b0;
    end else begin
      fell <= 1'b1;
    end
  end

  // Past 16 bits the received stream follows, delayed by one word
  always_ff @(negedge sclk_link or posedge link_clr) begin
    if (link_clr) begin
      so_bit <= 1'b0;
    end else if (!cs_n) begin
      if (cnt >= FRAME_MIN) begin
        so_bit <= rx_shift[WORD_W-1];
      end else begin
        so_bit <= tx_word[TX_MSB - cnt[3:0]];
      end
    end
  end

  // First bit stands from select falling until the first falling clock
  assign so = fell ? so_bit : tx_word[WORD_W-1];
  assign so_oe = ~cs_n & ~rp_s2;

  // ==========================================================
  // System domain: status snapshot, frame acceptance, flags
  logic cs_rise;
  logic accept;

  // One-cycle pulse once the synchronised select is back high
  assign cs_rise = cs_s2 & ~cs_s3;
  // Count and data are quiet here: the clock stays low at select rising
  assign accept = cs_rise & (tg_s2 != tog_seen) & (cnt == FRAME_MIN)
                  & ~rp_s2;

  // Snapshot frozen while selected so the link sees a steady word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_word <= WORD_RST;
    end else if (cs_s2) begin
      tx_word <= {status_of(fault_flags), echo_byte};
    end
  end

  // A frame with no pulse leaves the toggle alone and is discarded
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tog_seen <= 1'b0;
    end else if (cs_rise) begin
      tog_seen <= tg_s2;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || rp_s2) begin
      cmd_word <= WORD_RST;
      echo_byte <= BYTE_RST;
    end else if (accept) begin
      cmd_word <= rx_shift;
      echo_byte <= rx_shift[BYTE_W-1:0];
    end
  end

  // New fault in the clearing cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n || rp_s2) begin
      fault_flags <= FLAGS_RST;
    end else if (accept) begin
      fault_flags <= fault_set;
    end else begin
      fault_flags <= fault_flags | fault_set;
    end
  end

  // Exactly one of these pulses follows every synchronised select rise
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_done <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      frame_done <= accept;
      frame_err <= cs_rise & ~accept;
    end
  end

  // ==========================================================
  // Assertions
  a_fault_set_wins: assert property (
    @(posedge clk_sys) disable iff (!rst_n || rp_s1 || rp_s2)
    (fault_set != FLAGS_RST)
    |=> ((fault_flags & $past(fault_set)) == $past(fault_set)))
    else $error("fault event lost");

  a_accept_loads_cmd: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    accept |=> (cmd_word == $past(rx_shift)) && frame_done)
    else $error("command word not applied");

  a_reject_keeps_state: assert property (
    @(posedge clk_sys) disable iff (!rst_n || rp_s2)
    (cs_rise && !accept) |=> $stable(cmd_word) && $stable(echo_byte)
    && frame_err)
    else $error("rejected frame changed state");

  a_echo_low_byte: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    accept |=> echo_byte == $past(rx_shift[BYTE_W-1:0]))
    else $error("echo byte wrong");

  a_clear_on_accept: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (accept && fault_set == FLAGS_RST) |=> fault_flags == FLAGS_RST)
    else $error("flags not cleared");

  a_reset_pin_clears: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rp_s2 |=> (fault_flags == FLAGS_RST) && (cmd_word == WORD_RST)
    && (echo_byte == BYTE_RST))
    else $error("reset pin did not clear");

  // Pin reset releases the output two system clock edges after the pin rises, whatever select does
  a_reset_pin_hiz: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rp_s2 |-> !so_oe)
    else $error("output driven while reset pin high");

  a_oe_off_deselect: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cs_n |-> !so_oe)
    else $error("output driven while deselected");

  a_status_layout: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cs_s2 |=> tx_word[WORD_W-1:BYTE_W] == {$past(fault_flags[POS_CH4]),
      $past(fault_flags[POS_CH3]), $past(fault_flags[POS_CH2]),
      $past(fault_flags[POS_CH1]), $past(fault_flags[POS_CH5]), STAT_PAD})
    else $error("status byte layout wrong");

  a_capture_si: assert property (
    @(posedge sclk_link) disable iff (link_clr)
    !cs_n |=> rx_shift[0] == $past(si))
    else $error("input bit not captured");

  a_shift_out_tx: assert property (
    @(posedge sclk_link) disable iff (link_clr || cs_n)
    (fell && started && cnt < FRAME_MIN)
    |-> so == tx_word[TX_MSB - cnt[3:0]])
    else $error("output bit out of order");

  // Bits past the first sixteen repeat the input stream one word late
  a_pass_through: assert property (
    @(posedge sclk_link) disable iff (link_clr || cs_n)
    (fell && cnt >= FRAME_MIN) |-> so == rx_shift[WORD_W-1])
    else $error("pass-through bit wrong");

  a_first_bit: assert property (
    @(posedge sclk_link) disable iff (link_clr || cs_n)
    !started |-> so == tx_word[WORD_W-1])
    else $error("first status bit wrong");

  a_count_first: assert property (
    @(posedge sclk_link) disable iff (link_clr || cs_n)
    !started |=> cnt == CNT_ONE)
    else $error("pulse count did not restart");

  a_count_wrap: assert property (
    @(posedge sclk_link) disable iff (link_clr || cs_n)
    (started && cnt == FRAME_WRAP) |=> cnt == FRAME_MIN)
    else $error("pulse count did not wrap");

  a_snapshot_frozen: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !cs_s2 |=> $stable(tx_word))
    else $error("status snapshot moved while selected");

  a_status_pad: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    tx_word[WORD_W-NUM_CH-1:BYTE_W] == STAT_PAD)
    else $error("status pad bits not zero");

  a_flags_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n || rp_s2)
    (!accept && fault_set == FLAGS_RST) |=> $stable(fault_flags))
    else $error("fault flags changed without cause");

  a_cmd_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n || rp_s2)
    !accept |=> $stable(cmd_word) && $stable(echo_byte))
    else $error("command word changed without a frame");

  a_done_one_cycle: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    frame_done |=> !frame_done)
    else $error("frame done longer than one cycle");

  a_done_or_err: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(frame_done && frame_err))
    else $error("frame both accepted and discarded");

  a_bad_count_err: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cs_rise && cnt != FRAME_MIN) |=> frame_err && !frame_done)
    else $error("wrong pulse count accepted");

  // ==========================================================
  // Cover points
  c_frame_16: cover property (
    @(posedge clk_sys) accept && rx_shift[BYTE_W-1:0] != BYTE_RST);
  c_frame_wrapped: cover property (
    @(posedge sclk_link) !cs_n && cnt == FRAME_WRAP);
  c_frame_reject: cover property (
    @(posedge clk_sys) cs_rise && !accept && !rp_s2);
  c_reset_frame: cover property (
    @(posedge clk_sys) cs_rise && rp_s2);
  c_status_ch4: cover property (
    @(posedge clk_sys) !cs_s2 && tx_word[WORD_W-1]);

endmodule // sfspi_slave
`default_nettype wire

// ---- testbench/sfspi_master_model.sv ----
// Serial master model driving the link side of the slave
`timescale 1ns/10ps
`default_nettype none
module sfspi_master_model (
  output logic sclk_link,
  output logic cs_n,
  output logic si,
  input wire logic so_line
);
  initial begin
    sclk_link = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // ==========================================================
  // One frame of n pulses, MSB first, select moved with clock low
  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = 32'h0000_0000;
    #7;
    cs_n = 1'b0;
    #128;
    for (int i = 0; i < n; i++) begin
      si = tx[n-1-i];
      #32 sclk_link = 1'b1;
      rx = {rx[30:0], so_line};
      #32 sclk_link = 1'b0;
    end
    #32 cs_n = 1'b1;
    // Released input sits at its pull-down level
    si = 1'b0;
    #1200;
  endtask
endmodule // sfspi_master_model
`default_nettype wire

// ---- testbench/tb_solenoid_fault_spi_slave.sv ----
// Self-checking bench for the solenoid fault serial slave
`timescale 1ns/10ps
`default_nettype none
module tb_solenoid_fault_spi_slave;
  import sfspi_pkg::*;
  logic clk_sys, rst_n, reset_pin, so, so_oe, frame_done, frame_err;
  logic sclk_link, cs_n, si;
  logic [NUM_CH-1:0] fault_set, fault_flags;
  logic [WORD_W-1:0] cmd_word;
  logic [BYTE_W-1:0] echo_byte;
  logic [31:0] rx;
  logic [7:0] n_done, n_err, d, e;
  int fail_count, check_count;
  wire so_line = so_oe ? so : 1'b1;
  sfspi_slave u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .sclk_link(sclk_link), .cs_n(cs_n), .si(si), .reset_pin(reset_pin),
    .fault_set(fault_set), .so(so), .so_oe(so_oe), .cmd_word(cmd_word),
    .echo_byte(echo_byte), .fault_flags(fault_flags),
    .frame_done(frame_done), .frame_err(frame_err));
  sfspi_master_model u_mst (.sclk_link(sclk_link), .cs_n(cs_n), .si(si),
    .so_line(so_line));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (frame_done === 1'b1) n_done <= n_done + 8'h01;
    if (frame_err === 1'b1) n_err <= n_err + 8'h01;
  end
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic set_flt(input logic [4:0] f);
    @(negedge clk_sys) fault_set = f;
    @(negedge clk_sys) fault_set = 5'h00;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  task automatic t_idle;
    chk(cmd_word | echo_byte | fault_flags, 32'h0000_0000);
    chk({so_oe, so_line}, 32'h0000_0001);
    $display("test idle done");
  endtask
  task automatic t_echo;
    set_flt(5'h15);
    d = n_done;
    u_mst.xfer(16, 32'h0000_a5c3, rx);
    chk(rx[15:0], 32'h0000_5800);
    chk(n_done - d, 32'h0000_0001);
    chk({cmd_word, echo_byte}, 32'h00a5_c3c3);
    chk(fault_flags, 32'h0000_0000);
    u_mst.xfer(16, 32'h0000_3c96, rx);
    chk(rx[15:0], 32'h0000_00c3);
    $display("test echo done");
  endtask
  task automatic t_bad;
    int cnt[3] = '{8, 17, 23};
    set_flt(5'h02);
    foreach (cnt[i]) begin
      e = n_err;
      u_mst.xfer(cnt[i], 32'hffff_ffff, rx);
      chk((rx >> (cnt[i] - 8)) & 32'h0000_00ff, 32'h0000_0020);
      chk(n_err - e, 32'h0000_0001);
      chk({cmd_word, echo_byte}, 32'h003c_9696);
      chk(fault_flags, 32'h0000_0002);
    end
    $display("test bad count done");
  endtask
  task automatic t_long;
    u_mst.xfer(24, 32'h0012_3456, rx);
    chk(rx[23:0], 32'h0020_9612);
    chk({cmd_word, echo_byte}, 32'h0034_5656);
    chk(fault_flags, 32'h0000_0000);
    $display("test long done");
  endtask
  task automatic t_rstpin;
    set_flt(5'h1f);
    @(negedge clk_sys) reset_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(cmd_word | echo_byte | fault_flags, 32'h0000_0000);
    e = n_err;
    u_mst.xfer(16, 32'h0000_1234, rx);
    chk(rx[15:0], 32'h0000_ffff);
    chk(n_err - e, 32'h0000_0001);
    @(negedge clk_sys) reset_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    u_mst.xfer(16, 32'h0000_0055, rx);
    chk(rx[15:0], 32'h0000_0000);
    $display("test reset pin done");
  endtask
  task automatic t_chain;
    set_flt(5'h08);
    d = n_done;
    u_mst.xfer(32, 32'hdead_beef, rx);
    chk(rx, 32'h8055_dead);
    chk(n_done - d, 32'h0000_0001);
    chk({cmd_word, echo_byte}, 32'h00be_efef);
    chk(fault_flags, 32'h0000_0000);
    $display("test chain done");
  endtask
  initial begin
    #300000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    rst_n = 1'b0;
    reset_pin = 1'b0;
    fault_set = 5'h00;
    n_done = 8'h00;
    n_err = 8'h00;
    fail_count = 0;
    check_count = 0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_idle;
    t_echo;
    t_bad;
    t_long;
    t_rstpin;
    t_chain;
    tally_and_finish;
  end
endmodule // tb_solenoid_fault_spi_slave
`default_nettype wire
